// file: core/rcrm_top.sv
// Reset cause recording, software reset and boot memory remap.
// Assumes a classic Wishbone master on clk_i and asynchronous pins.
//
// Summary of operation
// - Every reset maps program memory at bottom.
// - Vector region spans 0x00 through 0x20.
// - Writing remap bit one mirrors SRAM low.
// - Writing remap bit zero restores program memory.
// - Any reset clears the remap bit.
// - Bit 4 reads one for small program memory.
// - Bit 3 reads one for small SRAM.
// - Kernel runs first, then jumps to zero if the boot pin is high.
// - Kernel code hidden from user reads, fetches.
// - Four reset sources are told apart.
// - Power-on reset sets cause bit 0.
// - Watchdog timeout sets cause bit 1.
// - Writing cause bit 2 forces software reset.
// - Ones written to clear register clear causes.
// - All-zero cause means external pin reset.
`timescale 1ns/1ns
module rcrm_top #(
  parameter bit FLASH_32K = 1'b0,
  parameter bit SRAM_4K   = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output      logic [31:0] dat_o,
  output      logic        ack_o,
  input  wire logic        ext_rst_n_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic        boot_select_pin_i,
  input  wire logic        kernel_done_i,
  input  wire logic        user_acc_i,
  input  wire logic [31:0] user_adr_i,
  input  wire logic [31:0] fetch_adr_i,
  output      logic        sys_rst_o,
  output      logic        kernel_active_o,
  output      logic        jump_o,
  output      logic [31:0] jump_vec_o,
  output      logic        low_sram_o,
  output      logic        vec_hit_o,
  output      logic        kernel_block_o,
  output      logic        irq_o
);

  rcrm_pkg::rcrm_state_t r_reg;
  rcrm_pkg::rcrm_state_t r_next;

  // True when the bus address selects the given register word.
  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] off);
    hit = (a == off);
  endfunction : hit

  // True when an address lies inside a closed window, both ends included.
  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  logic req;
  logic take;
  logic ack;
  logic wr0;
  logic wr_remap;
  logic wr_cause;
  logic wr_clr;
  logic wr_sts;
  logic wr_msk;
  logic ext_ev;
  logic sw_ev;
  logic wdt_ev;
  logic any_ev;
  logic [31:0] rd;

  // Bus handshake: a request is latched once, then acked one cycle later.
  assign req      = cyc_i & stb_i;
  assign take     = req & ~r_reg.pend;
  assign ack      = req & r_reg.pend;
  assign wr0      = ack & we_i & sel_i[0];
  assign wr_remap = wr0 & hit(adr_i, rcrm_pkg::REMAP_ADR);
  assign wr_cause = wr0 & hit(adr_i, rcrm_pkg::CAUSE_ADR);
  assign wr_clr   = wr0 & hit(adr_i, rcrm_pkg::CLEAR_ADR);
  assign wr_sts   = wr0 & hit(adr_i, rcrm_pkg::IRQ_STS_ADR);
  assign wr_msk   = wr0 & hit(adr_i, rcrm_pkg::IRQ_MSK_ADR);

  // Reset sources; the pin counts once the two late stages agree.
  assign ext_ev = r_reg.ext_lvl & ~r_reg.ext_s[1] & ~r_reg.ext_s[2];
  assign wdt_ev = wdt_timeout_i;
  assign sw_ev  = wr_cause & dat_i[rcrm_pkg::SW_BIT];
  assign any_ev = ext_ev | wdt_ev | sw_ev;

  // Read mux; unmapped and write-only words read as zero.
  always_comb begin
    rd = 32'h0;
    if (hit(adr_i, rcrm_pkg::REMAP_ADR)) begin
      rd[rcrm_pkg::REMAP_BIT] = r_reg.remap;
      rd[rcrm_pkg::SRAM4_BIT] = SRAM_4K;
      rd[rcrm_pkg::FLASH_BIT] = FLASH_32K;
    end else if (hit(adr_i, rcrm_pkg::CAUSE_ADR)) begin
      rd[2:0] = r_reg.cause;
    end else if (hit(adr_i, rcrm_pkg::IRQ_STS_ADR)) begin
      rd[3:0] = r_reg.sts;
    end else if (hit(adr_i, rcrm_pkg::IRQ_MSK_ADR)) begin
      rd[3:0] = r_reg.msk;
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    r_next      = r_reg;
    r_next.jump = 1'b0;
    // Three-stage pin synchronisers; stage one feeds stage two only.
    r_next.ext_s  = {r_reg.ext_s[1:0], ext_rst_n_i};
    r_next.boot_s = {r_reg.boot_s[1:0], boot_select_pin_i};
    if (r_reg.ext_s[1] == r_reg.ext_s[2]) begin
      r_next.ext_lvl = r_reg.ext_s[2];
    end
    if (r_reg.boot_s[1] == r_reg.boot_s[2]) begin
      r_next.boot_lvl = r_reg.boot_s[2];
    end
    // Bus request latch and registered read data.
    if (!req) begin
      r_next.pend = 1'b0;
    end else if (take) begin
      r_next.pend = 1'b1;
      r_next.dat  = rd;
    end else begin
      r_next.pend = 1'b0;
    end
    if (wr_remap) begin
      r_next.remap = dat_i[rcrm_pkg::REMAP_BIT];
    end
    if (wr_msk) begin
      r_next.msk = dat_i[3:0];
    end
    // Clears go first so that a cause arriving now still sticks.
    if (wr_clr) begin
      r_next.cause = r_reg.cause & ~dat_i[2:0];
    end
    if (wr_sts) begin
      r_next.sts = r_reg.sts & ~dat_i[3:0];
    end
    if (ext_ev) begin
      r_next.cause = 3'h0;
    end else begin
      if (wdt_ev) begin
        r_next.cause[rcrm_pkg::WDT_BIT] = 1'b1;
      end
      if (sw_ev) begin
        r_next.cause[rcrm_pkg::SW_BIT] = 1'b1;
      end
    end
    r_next.sts[rcrm_pkg::EXT_BIT] = r_next.sts[rcrm_pkg::EXT_BIT] | ext_ev;
    r_next.sts[rcrm_pkg::WDT_BIT] = r_next.sts[rcrm_pkg::WDT_BIT] | wdt_ev;
    r_next.sts[rcrm_pkg::SW_BIT]  = r_next.sts[rcrm_pkg::SW_BIT] | sw_ev;
    // Boot phase sequencing.
    case (r_reg.phase)
      rcrm_pkg::RCRM_RESET: begin
        if (r_reg.cnt != 5'h0) begin
          r_next.cnt = r_reg.cnt - 5'h1;
        end else begin
          r_next.phase = rcrm_pkg::RCRM_KERNEL;
        end
      end
      rcrm_pkg::RCRM_KERNEL: begin
        // With the boot pin low the kernel keeps control.
        if (kernel_done_i && r_reg.boot_lvl) begin
          r_next.jump  = 1'b1;
          r_next.phase = rcrm_pkg::RCRM_USER;
        end
      end
      rcrm_pkg::RCRM_USER: begin
      end
      default: begin
        r_next.phase = rcrm_pkg::RCRM_RESET;
      end
    endcase
    // Any reset, or the pin still held low, restarts the sequence.
    if (any_ev || !r_reg.ext_lvl) begin
      r_next.remap = 1'b0;
      r_next.cnt   = rcrm_pkg::RST_CYC;
      r_next.phase = rcrm_pkg::RCRM_RESET;
      r_next.jump  = 1'b0;
    end
  end

  // State register; power-on reset records its own cause.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg          <= '0;
      r_reg.cause    <= rcrm_pkg::CAUSE_RST;
      r_reg.sts      <= rcrm_pkg::STS_RST;
      r_reg.msk      <= rcrm_pkg::MSK_RST;
      r_reg.cnt      <= rcrm_pkg::RST_CYC;
      r_reg.phase    <= rcrm_pkg::RCRM_RESET;
      r_reg.ext_s    <= 3'h7;
      r_reg.ext_lvl  <= 1'b1;
      r_reg.boot_s   <= 3'h7;
      r_reg.boot_lvl <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs; address windows are decoded from the live address.
  assign dat_o           = r_reg.dat;
  assign ack_o           = ack;
  assign sys_rst_o       = (r_reg.phase == rcrm_pkg::RCRM_RESET);
  assign kernel_active_o = (r_reg.phase == rcrm_pkg::RCRM_KERNEL);
  assign jump_o          = r_reg.jump;
  assign jump_vec_o      = rcrm_pkg::BOOT_VEC;
  assign low_sram_o      = r_reg.remap;
  assign vec_hit_o       = in_win(fetch_adr_i, rcrm_pkg::VEC_FIRST,
                                  rcrm_pkg::VEC_LAST);
  // Only the kernel itself may touch its own code window.
  assign kernel_block_o  = user_acc_i &&
                           (r_reg.phase == rcrm_pkg::RCRM_USER) &&
                           in_win(user_adr_i, rcrm_pkg::KERN_FIRST,
                                  rcrm_pkg::KERN_LAST);
  assign irq_o           = |(r_reg.sts & r_reg.msk);

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_remap_set;
    wr_remap && dat_i[0] && !any_ev && r_reg.ext_lvl |=> low_sram_o;
  endproperty
  a_remap_set: assert property (p_remap_set)
    else $error("Remap write of one did not mirror SRAM.");

  property p_remap_clr;
    wr_remap && !dat_i[0] |=> !low_sram_o;
  endproperty
  a_remap_clr: assert property (p_remap_clr)
    else $error("Remap write of zero did not restore memory.");

  property p_reset_unmaps;
    any_ev |=> !low_sram_o && sys_rst_o;
  endproperty
  a_reset_unmaps: assert property (p_reset_unmaps)
    else $error("Reset left SRAM mirrored.");

  property p_por_cause;
    $fell(rst_i) |-> r_reg.cause == rcrm_pkg::CAUSE_RST;
  endproperty
  a_por_cause: assert property (@(posedge clk_i) p_por_cause)
    else $error("Power-on reset did not record its cause.");

  property p_wdt_cause;
    wdt_ev && !ext_ev |=> r_reg.cause[1] ##1 sys_rst_o;
  endproperty
  a_wdt_cause: assert property (p_wdt_cause)
    else $error("Watchdog cause bit not set.");

  property p_sw_reset;
    sw_ev && !ext_ev |=> r_reg.cause[2] ##0 sys_rst_o [*8];
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("Software reset not forced or not recorded.");

  property p_clear;
    wr_clr && dat_i[0] |=> !r_reg.cause[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear write did not clear the cause bit.");

  property p_ext_null;
    ext_ev |=> r_reg.cause == 3'h0;
  endproperty
  a_ext_null: assert property (p_ext_null)
    else $error("External reset did not leave causes null.");

  property p_size_bits;
    ack && !we_i && hit(adr_i, rcrm_pkg::REMAP_ADR) |->
      dat_o[4] == FLASH_32K && dat_o[3] == SRAM_4K && dat_o[2:1] == 2'h0;
  endproperty
  a_size_bits: assert property (p_size_bits)
    else $error("Memory size bits read wrong.");

  property p_jump;
    kernel_active_o && kernel_done_i && r_reg.boot_lvl && !any_ev &&
      r_reg.ext_lvl |=> jump_o && !kernel_active_o;
  endproperty
  a_jump: assert property (p_jump)
    else $error("Kernel did not hand over to the reset vector.");

  // Reserved bits and the write-only clear word must read back as zero.
  property p_remap_rsvd;
    ack && !we_i && hit(adr_i, rcrm_pkg::REMAP_ADR) |->
      dat_o[31:5] == 27'h0;
  endproperty
  a_remap_rsvd: assert property (p_remap_rsvd)
    else $error("Reserved remap bits did not read zero.");

  property p_cause_rsvd;
    ack && !we_i && hit(adr_i, rcrm_pkg::CAUSE_ADR) |->
      dat_o[31:3] == 29'h0;
  endproperty
  a_cause_rsvd: assert property (p_cause_rsvd)
    else $error("Reserved cause bits did not read zero.");

  property p_clear_reads_zero;
    ack && !we_i && hit(adr_i, rcrm_pkg::CLEAR_ADR) |->
      dat_o == 32'h0;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("Write-only clear word did not read zero.");

  property p_clear_zero;
    wr_clr && dat_i[2:0] == 3'h0 && !any_ev |=> $stable(r_reg.cause);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Writing zeros to the clear word changed a cause.");

  property p_vec_last;
    fetch_adr_i == rcrm_pkg::VEC_LAST |-> vec_hit_o;
  endproperty
  a_vec_last: assert property (p_vec_last)
    else $error("Last vector address not decoded.");

  property p_vec_past;
    fetch_adr_i == rcrm_pkg::VEC_LAST + 32'h1 |-> !vec_hit_o;
  endproperty
  a_vec_past: assert property (p_vec_past)
    else $error("Address past the vectors decoded as a vector.");

  property p_kernel_hide;
    user_acc_i && !kernel_active_o && !sys_rst_o &&
      user_adr_i == rcrm_pkg::KERN_FIRST |-> kernel_block_o;
  endproperty
  a_kernel_hide: assert property (p_kernel_hide)
    else $error("User access reached the hidden kernel code.");

  property p_ext_hold;
    !r_reg.ext_lvl |=> sys_rst_o && !low_sram_o;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("External pin held low did not hold the reset.");

  property p_boot_low;
    kernel_active_o && !r_reg.boot_lvl && !any_ev && r_reg.ext_lvl |=>
      !jump_o && kernel_active_o;
  endproperty
  a_boot_low: assert property (p_boot_low)
    else $error("Kernel handed over with the boot pin low.");

  property p_por_unmapped;
    $fell(rst_i) |-> !low_sram_o && sys_rst_o;
  endproperty
  a_por_unmapped: assert property (p_por_unmapped)
    else $error("Power-on reset left SRAM mirrored.");

  property p_sw_hold;
    r_reg.cause[2] && !wr_clr && !ext_ev |=> r_reg.cause[2];
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("Software reset cause was lost without a clear.");

  property p_kernel_first;
    $fell(sys_rst_o) |-> kernel_active_o;
  endproperty
  a_kernel_first: assert property (p_kernel_first)
    else $error("Reset did not hand control to the kernel.");

  c_sw: cover property (sw_ev);
  c_wdt: cover property (wdt_ev ##1 sys_rst_o);
  c_remap: cover property (wr_remap && dat_i[0]);
  c_jump: cover property (jump_o);
  c_ext: cover property (ext_ev);

endmodule : rcrm_top

// file: core/rcrm_pkg.sv
// Constants and types for the reset cause and memory remap block.
// Assumes a 20 MHz core clock and a 32-bit classic Wishbone bus.
package rcrm_pkg;

  // Register byte addresses.
  localparam logic [31:0] REMAP_ADR   = 32'hffff0220;
  localparam logic [31:0] CAUSE_ADR   = 32'hffff0230;
  localparam logic [31:0] CLEAR_ADR   = 32'hffff0234;
  localparam logic [31:0] IRQ_STS_ADR = 32'hffff0238;
  localparam logic [31:0] IRQ_MSK_ADR = 32'hffff023c;

  // Field positions.
  localparam int REMAP_BIT  = 0;
  localparam int SRAM4_BIT  = 3;
  localparam int FLASH_BIT  = 4;
  localparam int POR_BIT    = 0;
  localparam int WDT_BIT    = 1;
  localparam int SW_BIT     = 2;
  localparam int EXT_BIT    = 3;

  // Reset values.
  localparam logic [2:0] CAUSE_RST = 3'h1;
  localparam logic [3:0] STS_RST   = 4'h1;
  localparam logic [3:0] MSK_RST   = 4'h0;

  // Address windows: vector table and hidden kernel code.
  localparam logic [31:0] VEC_FIRST  = 32'h00000000;
  localparam logic [31:0] VEC_LAST   = 32'h00000020;
  localparam logic [31:0] BOOT_VEC   = 32'h00000000;
  localparam logic [31:0] KERN_FIRST = 32'h0008f800;
  localparam logic [31:0] KERN_LAST  = 32'h0008ffff;

  // Length of the system reset pulse.
  localparam int CLK_NS      = 50;
  localparam int RST_TIME_NS = 1000;
  localparam int RST_CYC_I   = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] RST_CYC = 5'(RST_CYC_I);

  // Boot phase after any reset.
  typedef enum logic [1:0] {
    RCRM_RESET,
    RCRM_KERNEL,
    RCRM_USER
  } rcrm_phase_t;

  typedef struct packed {
    logic        remap;
    logic [2:0]  cause;
    logic [3:0]  sts;
    logic [3:0]  msk;
    logic        pend;
    logic [31:0] dat;
    logic [4:0]  cnt;
    rcrm_phase_t phase;
    logic        jump;
    logic [2:0]  ext_s;
    logic        ext_lvl;
    logic [2:0]  boot_s;
    logic        boot_lvl;
  } rcrm_state_t;

endpackage : rcrm_pkg

// file: tb/rcrm_cpu_model.sv
// Core-side model: the processor reaching the block over classic Wishbone.
// Assumes the block answers each request with one ack cycle on clk_i.
`timescale 1ns/1ns
module rcrm_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output      logic        cyc_o,
  output      logic        stb_o,
  output      logic        we_o,
  output      logic [31:0] adr_o,
  output      logic [3:0]  sel_o,
  output      logic [31:0] dat_o
);
  // Idle bus from time zero; only the low byte carries register bits.
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 32'h0;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end

  // One single cycle; must be entered just after a rising edge.
  // The request stands until the rising edge at which ack is sampled high,
  // read data is taken at that edge, then the bus idles for a full cycle.
  // No answer time is assumed; only the bench watchdog ends a lost wait.
  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= wd;
    @(posedge clk_i);
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    @(posedge clk_i);
  endtask : acc
endmodule : rcrm_cpu_model

// file: tb/rcrm_top_tb_top.sv
// Self-checking bench for the reset cause and memory remap block.
// Assumes rcrm_cpu_model as bus master and a 20 MHz clock.
`timescale 1ns/1ns
module rcrm_top_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ext_n = 1'b1;
  logic        wdt = 1'b0;
  logic        kdone = 1'b0;
  logic        bsel = 1'b1;
  logic        uacc = 1'b0;
  logic [31:0] uadr = 32'h0;
  logic [31:0] fadr = 32'h0;
  logic        cyc, stb, we, ack, srst, kact, jmp, lsram, vhit, kblk, irq;
  logic [31:0] adr, wdat, rdat, jvec;
  logic [3:0]  sel;
  int          failures = 0;
  int          n_compared = 0;
  int          nj;

  // Free-running 50 ns clock.
  always #25 clk = ~clk;

  rcrm_cpu_model cpu (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  rcrm_top #(.FLASH_32K(1'b1), .SRAM_4K(1'b0)) dut (.clk_i(clk),
    .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .ext_rst_n_i(ext_n), .wdt_timeout_i(wdt), .boot_select_pin_i(bsel),
    .kernel_done_i(kdone), .user_acc_i(uacc), .user_adr_i(uadr),
    .fetch_adr_i(fadr), .sys_rst_o(srst), .kernel_active_o(kact),
    .jump_o(jmp), .jump_vec_o(jvec), .low_sram_o(lsram),
    .vec_hit_o(vhit), .kernel_block_o(kblk), .irq_o(irq));

  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    cpu.acc(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input string nm, input logic [31:0] a,
                    input logic [31:0] e);
    logic [31:0] x;
    cpu.acc(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask : rd

  // Waits out the system reset pulse until the kernel phase starts.
  // A kernel phase that never starts is left to the watchdog.
  task automatic boot();
    while (kact !== 1'b1) begin
      @(negedge clk);
    end
    @(posedge clk);
  endtask : boot

  // Main sequence; inputs move by non-blocking assignment after an edge.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    boot();
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h01);
    rd("remap", rcrm_pkg::REMAP_ADR, 32'h10);
    chk("low_sram", 32'h0, {31'h0, lsram});
    rd("unmapped", 32'hffff0224, 32'h0);
    wr(rcrm_pkg::CLEAR_ADR, 32'h0);
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h01);
    rd("clear", rcrm_pkg::CLEAR_ADR, 32'h0);
    rd("irq_sts", rcrm_pkg::IRQ_STS_ADR, 32'h1);
    wr(rcrm_pkg::IRQ_MSK_ADR, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(rcrm_pkg::IRQ_STS_ADR, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    fadr <= 32'h00000020;
    @(negedge clk);
    chk("vec_hit", 32'h1, {31'h0, vhit});
    @(posedge clk);
    fadr <= 32'h00000021;
    @(negedge clk);
    chk("vec_hit", 32'h0, {31'h0, vhit});
    @(posedge clk);
    // Remap writes come from code above the mirror, as a real core must.
    fadr <= 32'h00080024;
    kdone <= 1'b1;
    @(posedge clk);
    kdone <= 1'b0;
    nj = 0;
    repeat (4) begin
      @(negedge clk);
      nj += (jmp === 1'b1) ? 1 : 0;
    end
    chk("jumps", 32'h1, 32'(nj));
    chk("jump_vec", 32'h0, jvec);
    chk("kernel", 32'h0, {31'h0, kact});
    @(posedge clk);
    uacc <= 1'b1;
    uadr <= 32'h0008f800;
    @(negedge clk);
    chk("kblock", 32'h1, {31'h0, kblk});
    @(posedge clk);
    uadr <= 32'h0008f7fc;
    @(negedge clk);
    chk("kblock", 32'h0, {31'h0, kblk});
    @(posedge clk);
    uacc <= 1'b0;
    wr(rcrm_pkg::REMAP_ADR, 32'hff);
    rd("remap", rcrm_pkg::REMAP_ADR, 32'h11);
    chk("low_sram", 32'h1, {31'h0, lsram});
    wr(rcrm_pkg::REMAP_ADR, 32'h0);
    chk("low_sram", 32'h0, {31'h0, lsram});
    wr(rcrm_pkg::REMAP_ADR, 32'h1);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (3) @(posedge clk);
    chk("sys_rst", 32'h1, {31'h0, srst});
    boot();
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h03);
    chk("low_sram", 32'h0, {31'h0, lsram});
    wr(rcrm_pkg::CLEAR_ADR, 32'h01);
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h02);
    wr(rcrm_pkg::CLEAR_ADR, 32'h07);
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h00);
    wr(rcrm_pkg::CAUSE_ADR, 32'h04);
    repeat (3) @(posedge clk);
    boot();
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h04);
    ext_n <= 1'b0;
    repeat (8) @(posedge clk);
    ext_n <= 1'b1;
    boot();
    rd("cause", rcrm_pkg::CAUSE_ADR, 32'h00);
    // The external reset leaves its sticky status bit behind.
    wr(rcrm_pkg::IRQ_MSK_ADR, 32'h8);
    chk("irq_ext", 32'h1, {31'h0, irq});
    // Boot pin low: the kernel keeps control and never jumps.
    bsel <= 1'b0;
    repeat (4) @(posedge clk);
    kdone <= 1'b1;
    @(posedge clk);
    kdone <= 1'b0;
    repeat (3) @(posedge clk);
    chk("kernel_hold", 32'h1, {31'h0, kact});
    end_of_test();
  end

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : rcrm_top_tb_top
